// File: logic/hapr_top.sv
// home agent pool readiness: capability/status registers, readiness timer,
// pool and discovery flags, interrupt status and mask
// assumes one 25 MHz clock; attribute, training, shrink and flr inputs come
// from logic on the same clock; registers reached over a plain strobe port
`timescale 1ns/100ps
`include "hapr_map.svh"

module hapr_top #(
  parameter hapr_pkg::hapr_count_t CONV_COUNT = `HAPR_CONV_COUNT,
  parameter hapr_pkg::hapr_exp_t   CONV_EXP   = `HAPR_CONV_EXP,
  parameter hapr_pkg::hapr_count_t FLR_COUNT  = `HAPR_FLR_COUNT,
  parameter hapr_pkg::hapr_exp_t   FLR_EXP    = `HAPR_FLR_EXP,
  parameter logic [11:0]           ELO_VALUE  = `HAPR_ELO_VALUE
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire hapr_pkg::hapr_addr_t addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic [31:0]               rdata,
  input  wire logic                 flr,
  input  wire logic                 attr_known,
  input  wire logic                 training_done,
  input  wire logic                 shrink_valid,
  input  wire hapr_pkg::hapr_count_t shrink_count,
  input  wire hapr_pkg::hapr_exp_t  shrink_exp,
  output logic                      pool_ready_flag,
  output logic                      discovery_ready_flag,
  output logic                      irq
);

  // ------------------------------------------------------------
  // readiness time arithmetic
  // ------------------------------------------------------------
  function automatic hapr_pkg::hapr_time_t time_ns(input hapr_pkg::hapr_count_t c,
                                                   input hapr_pkg::hapr_exp_t e);
    logic [5:0] sh;
    sh = {3'h0, e} * `HAPR_SCALE_LOG2;
    time_ns = hapr_pkg::hapr_time_t'(c) << sh;
  endfunction

  // the longer of the two reset cases is the one that is reported
  localparam logic USE_CONV = time_ns(CONV_COUNT, CONV_EXP)
                              >= time_ns(FLR_COUNT, FLR_EXP);
  localparam hapr_pkg::hapr_count_t RST_COUNT = USE_CONV ? CONV_COUNT : FLR_COUNT;
  localparam hapr_pkg::hapr_exp_t   RST_EXP   = USE_CONV ? CONV_EXP : FLR_EXP;

  hapr_pkg::hapr_count_t   pool_ready_time_count;
  hapr_pkg::hapr_exp_t     pool_ready_time_exponent;
  hapr_pkg::hapr_time_t    cur_time;
  hapr_pkg::hapr_time_t    elapsed;
  hapr_pkg::hapr_phase_e   phase;
  logic                    shrink_ok;
  logic                    deadline_hit;
  logic [`HAPR_IRQ_W-1:0]  irq_event;
  logic [`HAPR_IRQ_W-1:0]  irq_stat;
  logic [`HAPR_IRQ_W-1:0]  irq_mask;
  logic [31:0]             next_rdata;

  assign cur_time  = time_ns(pool_ready_time_count, pool_ready_time_exponent);
  assign shrink_ok = shrink_valid && (phase != hapr_pkg::HAPR_READY)
                     && (time_ns(shrink_count, shrink_exp) <= cur_time);
  // elapsed lags true time by one period; look two ahead so the flag is up in time
  assign deadline_hit = (elapsed + `HAPR_CLK_PERIOD_NS + `HAPR_CLK_PERIOD_NS) >= cur_time;

  // ------------------------------------------------------------
  // readiness fields
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pool_ready_time_count    <= RST_COUNT;
      pool_ready_time_exponent <= RST_EXP;
    end else if (shrink_ok) begin
      pool_ready_time_count    <= shrink_count;
      pool_ready_time_exponent <= shrink_exp;
    end
  end

  // time since the last reset, held once deadline_hit is set or the block is fully ready
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      elapsed <= '0;
    end else if (flr) begin
      elapsed <= '0;
    end else if (phase != hapr_pkg::HAPR_READY && !deadline_hit) begin
      elapsed <= elapsed + `HAPR_CLK_PERIOD_NS;
    end
  end

  // ------------------------------------------------------------
  // readiness sequence
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase                <= hapr_pkg::HAPR_WAIT_POOL;
      pool_ready_flag      <= 1'b0;
      discovery_ready_flag <= 1'b0;
    end else if (flr) begin
      phase                <= hapr_pkg::HAPR_WAIT_POOL;
      pool_ready_flag      <= 1'b0;
      discovery_ready_flag <= 1'b0;
    end else begin
      case (phase)
        hapr_pkg::HAPR_WAIT_POOL: begin
          // pre-training sizes are reported at the deadline at the latest
          if (attr_known || deadline_hit) begin
            pool_ready_flag <= 1'b1;
            phase           <= hapr_pkg::HAPR_WAIT_TRAIN;
          end
        end
        hapr_pkg::HAPR_WAIT_TRAIN: begin
          if (training_done) begin
            discovery_ready_flag <= 1'b1;
            phase                <= hapr_pkg::HAPR_READY;
          end
        end
        hapr_pkg::HAPR_READY: begin
          phase <= hapr_pkg::HAPR_READY;
        end
        default: begin
          phase <= hapr_pkg::HAPR_WAIT_POOL;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  always_comb begin
    irq_event = '0;
    irq_event[`HAPR_IRQ_POOL]    = !flr && phase == hapr_pkg::HAPR_WAIT_POOL
                                   && (attr_known || deadline_hit);
    irq_event[`HAPR_IRQ_DISC]    = !flr && phase == hapr_pkg::HAPR_WAIT_TRAIN
                                   && training_done;
    irq_event[`HAPR_IRQ_FORCED]  = !flr && phase == hapr_pkg::HAPR_WAIT_POOL
                                   && !attr_known && deadline_hit;
    irq_event[`HAPR_IRQ_REFUSED] = shrink_valid && !shrink_ok;
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= '0;
    end else if (wr && addr == `HAPR_OFS_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~wdata[`HAPR_IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= '0;
    end else if (wr && addr == `HAPR_OFS_IRQ_MASK) begin
      irq_mask <= wdata[`HAPR_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ------------------------------------------------------------
  // register reads; writes to read-only words are dropped
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (rd) begin
      case (addr)
        `HAPR_OFS_CAPSTAT: begin
          next_rdata[`HAPR_CNT_MSB:`HAPR_CNT_LSB] = pool_ready_time_count;
          next_rdata[`HAPR_EXP_MSB:`HAPR_EXP_LSB] = pool_ready_time_exponent;
          next_rdata[`HAPR_POOL_BIT]              = pool_ready_flag;
          next_rdata[`HAPR_DISC_BIT]              = discovery_ready_flag;
        end
        `HAPR_OFS_ERRLOG: begin
          next_rdata[`HAPR_ELO_MSB:`HAPR_ELO_LSB] = ELO_VALUE;
        end
        `HAPR_OFS_IRQ_STAT: begin
          next_rdata[`HAPR_IRQ_W-1:0] = irq_stat;
        end
        `HAPR_OFS_IRQ_MASK: begin
          next_rdata[`HAPR_IRQ_W-1:0] = irq_mask;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_pool_wait;
    phase == hapr_pkg::HAPR_WAIT_POOL && !flr;
  endsequence

  sequence s_train_end;
    phase == hapr_pkg::HAPR_WAIT_TRAIN && training_done && !flr;
  endsequence

  sequence s_cap_read;
    rd && addr == `HAPR_OFS_CAPSTAT;
  endsequence

  time_never_rises_a: assert property (
    cur_time <= $past(cur_time)
  ) else $error("reported readiness time went up");

  zero_count_ready_a: assert property (
    s_pool_wait ##0 (pool_ready_time_count == 9'h000) |=> pool_ready_flag
  ) else $error("zero count did not give pool ready at once");

  pool_by_deadline_a: assert property (
    !flr && !$past(flr) && elapsed >= cur_time |-> pool_ready_flag
  ) else $error("pool ready flag late");

  disc_after_pool_a: assert property (
    discovery_ready_flag |-> pool_ready_flag
  ) else $error("discovery ready without pool ready");

  disc_on_train_a: assert property (
    s_train_end |=> discovery_ready_flag && pool_ready_flag
  ) else $error("training done did not set both flags");

  shrink_taken_a: assert property (
    shrink_ok |=> pool_ready_time_count == $past(shrink_count)
                  && pool_ready_time_exponent == $past(shrink_exp)
  ) else $error("permitted reduction not applied");

  ro_write_ignored_a: assert property (
    wr && addr == `HAPR_OFS_CAPSTAT && !shrink_valid && !flr |=>
      $stable(pool_ready_time_count) && $stable(pool_ready_time_exponent)
      && pool_ready_flag == ($past(pool_ready_flag) || $past(irq_event[`HAPR_IRQ_POOL]))
  ) else $error("write changed read-only readiness fields");

  cap_read_data_a: assert property (
    s_cap_read |=> rdata[`HAPR_CNT_MSB:`HAPR_CNT_LSB] == $past(pool_ready_time_count)
                   && rdata[`HAPR_EXP_MSB:`HAPR_EXP_LSB] == $past(pool_ready_time_exponent)
                   && rdata[`HAPR_POOL_BIT] == $past(pool_ready_flag)
  ) else $error("capability read returned wrong fields");

  errlog_zero_a: assert property (
    rd && addr == `HAPR_OFS_ERRLOG |=> rdata[`HAPR_ELO_LSB-1:0] == 20'h00000
  ) else $error("reserved bits of error log word not zero");

  event_set_wins_a: assert property (
    irq_event[`HAPR_IRQ_POOL] |=> irq_stat[`HAPR_IRQ_POOL]
  ) else $error("pool ready event lost");

  pool_on_deadline_a: assert property (
    s_pool_wait ##0 deadline_hit |=> pool_ready_flag
  ) else $error("pool ready flag not forced at deadline");

  pool_attr_known_a: assert property (
    s_pool_wait ##0 attr_known |=> pool_ready_flag && !discovery_ready_flag
  ) else $error("known attributes did not give pool ready alone");

  shrink_refused_a: assert property (
    shrink_valid && !shrink_ok |=> $stable(pool_ready_time_count)
                                   && $stable(pool_ready_time_exponent)
  ) else $error("refused reduction changed the reported pair");

  flr_clears_flags_a: assert property (
    flr |=> !pool_ready_flag && !discovery_ready_flag
  ) else $error("function level reset left a flag set");

  errlog_value_a: assert property (
    rd && addr == `HAPR_OFS_ERRLOG |=> rdata[`HAPR_ELO_MSB:`HAPR_ELO_LSB] == ELO_VALUE
  ) else $error("error log offset field wrong");

  rdata_idle_zero_a: assert property (
    !rd |=> rdata == 32'h00000000
  ) else $error("read data stood longer than one cycle");

endmodule

// File: logic/hapr_map.svh
// register offsets, field positions, reset values and timing figures
// of the home agent pool readiness block; included by the design file
`ifndef HAPR_MAP_SVH
`define HAPR_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define HAPR_OFS_CAPSTAT   8'h00
`define HAPR_OFS_ERRLOG    8'h08
`define HAPR_OFS_IRQ_STAT  8'h10
`define HAPR_OFS_IRQ_MASK  8'h14

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define HAPR_DISC_BIT      0
`define HAPR_CNT_LSB       19
`define HAPR_CNT_MSB       27
`define HAPR_EXP_LSB       28
`define HAPR_EXP_MSB       30
`define HAPR_POOL_BIT      31
`define HAPR_ELO_LSB       20
`define HAPR_ELO_MSB       31

// ------------------------------------------------------------
// interrupt status bits
// ------------------------------------------------------------
`define HAPR_IRQ_W         4
`define HAPR_IRQ_POOL      0
`define HAPR_IRQ_DISC      1
`define HAPR_IRQ_FORCED    2
`define HAPR_IRQ_REFUSED   3

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define HAPR_CONV_COUNT    9'h010
`define HAPR_CONV_EXP      3'h1
`define HAPR_FLR_COUNT     9'h008
`define HAPR_FLR_EXP       3'h1
`define HAPR_ELO_VALUE     12'h000
`define HAPR_SCALE_LOG2    6'h05
`define HAPR_CLK_PERIOD_NS 45'h28

`endif

// File: logic/hapr_pkg.sv
// types shared by the home agent pool readiness block
// assumes nothing of its surroundings
package hapr_pkg;
  typedef logic [8:0]  hapr_count_t;
  typedef logic [2:0]  hapr_exp_t;
  typedef logic [44:0] hapr_time_t;
  typedef logic [7:0]  hapr_addr_t;
  typedef enum logic [1:0] {
    HAPR_WAIT_POOL,
    HAPR_WAIT_TRAIN,
    HAPR_READY
  } hapr_phase_e;
endpackage

// File: testbench/tb_home_agent_pool_readiness.sv
// self-checking bench of the home agent pool readiness block
// assumes the default count/exponent pairs and one 25 MHz clock
`timescale 1ns/100ps
`include "hapr_map.svh"

`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end

module tb_home_agent_pool_readiness;
  logic                  clk;
  logic                  rstn;
  hapr_pkg::hapr_addr_t  addr;
  logic [31:0]           wdata;
  logic                  wr;
  logic                  rd;
  logic [31:0]           rdata;
  logic                  flr;
  logic                  attr_known;
  logic                  training_done;
  logic                  shrink_valid;
  hapr_pkg::hapr_count_t shrink_count;
  hapr_pkg::hapr_exp_t   shrink_exp;
  logic                  pool_ready_flag;
  logic                  discovery_ready_flag;
  logic                  irq;
  int                    n_errors;
  int                    comparisons;
  int                    cyc;

  hapr_top dut (
    .clk                  (clk),
    .rstn                 (rstn),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .flr                  (flr),
    .attr_known           (attr_known),
    .training_done        (training_done),
    .shrink_valid         (shrink_valid),
    .shrink_count         (shrink_count),
    .shrink_exp           (shrink_exp),
    .pool_ready_flag      (pool_ready_flag),
    .discovery_ready_flag (discovery_ready_flag),
    .irq                  (irq)
  );

  always #20 clk = ~clk;

  // edges since reset release
  always @(posedge clk or negedge rstn) begin
    if (!rstn) cyc <= 0;
    else cyc <= cyc + 1;
  end

  // ------------------------------------------------------------
  // bus and stimulus tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] cap(logic p, logic [2:0] e, logic [8:0] c, logic d);
    return {p, e, c, 18'h0, d};
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic shrink(logic [8:0] c, logic [2:0] e);
    @(posedge clk);
    shrink_valid <= 1'b1;
    shrink_count <= c;
    shrink_exp   <= e;
    @(posedge clk);
    shrink_valid <= 1'b0;
    #1;
  endtask

  task automatic pulse_flr();
    @(posedge clk);
    flr <= 1'b1;
    @(posedge clk);
    flr <= 1'b0;
    #1;
  endtask

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    int          i;
    clk = 0; rstn = 0; addr = '0; wdata = '0; wr = 0; rd = 0; flr = 0;
    attr_known = 0; training_done = 0; shrink_valid = 0; shrink_count = '0; shrink_exp = '0;
    n_errors = 0; comparisons = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // reported pair is the longer of the two reset times
    reg_rd(`HAPR_OFS_CAPSTAT, d); `CHK(d, cap(1'b0, 3'h1, 9'h010, 1'b0))
    reg_rd(`HAPR_OFS_ERRLOG, d); `CHK(d, 32'h0)
    reg_rd(8'h04, d); `CHK(d, 32'h0)
    reg_wr(`HAPR_OFS_CAPSTAT, 32'hffffffff);
    reg_rd(`HAPR_OFS_CAPSTAT, d); `CHK(d, cap(1'b0, 3'h1, 9'h010, 1'b0))
    // no attributes: the deadline of 512 ns must force the flag
    for (i = 0; i < 20 && !pool_ready_flag; i++) tick(1);
    `CHK(pool_ready_flag, 1'b1)
    if (!pool_ready_flag) finish_test();
    // 512 ns after release: edge 12 is the last one in time
    `CHK(cyc <= 12, 1'b1)
    `CHK(discovery_ready_flag, 1'b0)
    reg_rd(`HAPR_OFS_IRQ_STAT, d); `CHK(d, 32'h5)
    `CHK(irq, 1'b0)
    reg_wr(`HAPR_OFS_IRQ_MASK, 32'h4);
    `CHK(irq, 1'b1)
    reg_wr(`HAPR_OFS_IRQ_STAT, 32'h4);
    `CHK(irq, 1'b0)
    reg_rd(`HAPR_OFS_IRQ_MASK, d); `CHK(d, 32'h4)
    @(posedge clk);
    training_done <= 1'b1;
    tick(2);
    `CHK(discovery_ready_flag, 1'b1)
    reg_rd(`HAPR_OFS_CAPSTAT, d); `CHK(d, cap(1'b1, 3'h1, 9'h010, 1'b1))
    // a shrink once ready is refused
    shrink(9'h004, 3'h0);
    reg_rd(`HAPR_OFS_CAPSTAT, d); `CHK(d[30:19], {3'h1, 9'h010})
    reg_rd(`HAPR_OFS_IRQ_STAT, d); `CHK(d, 32'hb)
    reg_wr(`HAPR_OFS_IRQ_MASK, 32'h8);
    `CHK(irq, 1'b1)
    reg_wr(`HAPR_OFS_IRQ_STAT, 32'hf);
    `CHK(irq, 1'b0)
    // function level reset keeps the pair and clears the flags
    @(posedge clk);
    training_done <= 1'b0;
    pulse_flr();
    `CHK({pool_ready_flag, discovery_ready_flag}, 2'b00)
    @(posedge clk);
    attr_known <= 1'b1;
    tick(2);
    `CHK({pool_ready_flag, discovery_ready_flag}, 2'b10)
    shrink(9'h004, 3'h0);
    reg_rd(`HAPR_OFS_CAPSTAT, d); `CHK(d[30:19], {3'h0, 9'h004})
    shrink(9'h008, 3'h1);
    reg_rd(`HAPR_OFS_CAPSTAT, d); `CHK(d[30:19], {3'h0, 9'h004})
    reg_rd(`HAPR_OFS_IRQ_STAT, d); `CHK(d, 32'h9)
    shrink(9'h000, 3'h0);
    reg_rd(`HAPR_OFS_CAPSTAT, d); `CHK(d[30:19], {3'h0, 9'h000})
    // count zero: ready at once after a reset
    @(posedge clk);
    attr_known <= 1'b0;
    pulse_flr();
    tick(1);
    `CHK(pool_ready_flag, 1'b1)
    reg_rd(`HAPR_OFS_CAPSTAT, d); `CHK(d[30:19], {3'h0, 9'h000})
    finish_test();
  end

  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule
